// ---- shared/dgs_pkg.sv ----
// Constants for the two-channel serial gain register bank.
// Assumes a 16-bit serial frame, MSB first, read on the block's own clock.
package dgs_pkg;

	// Frame layout
	localparam int          FRAME_BITS   = 16;    // Bits per access
	localparam int          BYTE_BITS    = 8;     // Bits per byte
	localparam int          RW_POS       = 15;    // read_not_write position
	localparam int          ADDR_MSB     = 11;    // Address field top
	localparam int          ADDR_LSB     = 8;     // Address field bottom
	localparam int          ADDR_W       = 4;     // Address field width
	localparam int          CNT_W        = 5;     // Edge counter width
	localparam logic [4:0]  CNT_FRAME    = 5'h10; // Rising edges in a full frame
	localparam logic [4:0]  CNT_BYTE     = 5'h08; // Rising edges in the first byte
	localparam logic [4:0]  CNT_MAX      = 5'h1F; // Saturation point

	// Register offsets
	localparam logic [3:0]  ADDR_GAIN_A  = 4'h3;  // gain_code_channel_a
	localparam logic [3:0]  ADDR_GAIN_B  = 4'h4;  // gain_code_channel_b
	localparam logic [3:0]  ADDR_CTRL    = 4'h5;  // channel_apply_control

	// Reset values and writable masks
	localparam logic [7:0]  GAIN_RESET   = 8'h50; // Code 80, least gain
	localparam logic [7:0]  CTRL_RESET   = 8'h03; // Both apply bits set
	localparam logic [7:0]  GAIN_MASK    = 8'h7F; // Bit 7 unused_bit
	localparam logic [7:0]  CTRL_MASK    = 8'h07; // Bits 7..3 unused_bit

	// Gain code: gain = 26 dB - code * 0.25 dB
	localparam int          GAIN_W       = 7;     // Code width
	localparam logic [6:0]  GAIN_CODE_MAX = 7'h50; // Largest legal code (80)

	// Channel control fields
	localparam int          CTRL_LINK    = 2;     // One register sets both
	localparam int          CTRL_APPLY_A = 1;     // Apply register 3 to A
	localparam int          CTRL_APPLY_B = 0;     // Apply register 4, or register 3 when linked, to B

	// Synchroniser
	localparam int          PIN_COUNT    = 3;     // sclk, chip select, data in

endpackage : dgs_pkg

// ---- core/dgs_pin_sync.sv ----
// Two-stage synchroniser for the serial pins.
// Assumes the pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module dgs_pin_sync (
	input  wire logic                          mclk,
	input  wire logic                          resetn,
	input  wire logic [dgs_pkg::PIN_COUNT-1:0] pinIn,
	input  wire logic [dgs_pkg::PIN_COUNT-1:0] pinReset,
	output var  logic [dgs_pkg::PIN_COUNT-1:0] pinSync
);
	import dgs_pkg::*;

	////////////////////////////////////////////////////////////////
	// One pair of flops per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_bit
			logic stage1_reg; // First stage, read only by second

			// Reset value per pin is fixed here: pin 1 (chip select) resets high, the others low
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					stage1_reg   <= (gi == 1) ? 1'b1 : 1'b0;
					pinSync[gi]  <= (gi == 1) ? 1'b1 : 1'b0;
				end else begin
					stage1_reg   <= pinIn[gi];
					pinSync[gi]  <= stage1_reg;
				end
			end
		end
	endgenerate

	// pinReset documents intended idle levels; kept for the header contract
	wire unusedReset = ^pinReset;

endmodule // dgs_pin_sync

`default_nettype wire

// ---- core/dgs_gain_regs.sv ----
// Serial register bank and gain routing for a two-channel amplifier.
// Assumes serial pins from an external controller, slower than mclk / 4.
`timescale 1ns/1ps
`default_nettype none

module dgs_gain_regs (
	input  wire logic                       mclk,          // 250 MHz core clock
	input  wire logic                       resetn,        // Async reset
	input  wire logic                       sclkPin,       // Serial clock pin
	input  wire logic                       chipSelectN,   // Chip select, low active
	input  wire logic                       sdiPin,        // Serial data in
	output var  logic                       sdoOut,        // Serial data out level
	output var  logic                       sdoOe,         // Serial data out enable
	output var  logic [dgs_pkg::GAIN_W-1:0] gainAppliedA,  // Code on channel A
	output var  logic [dgs_pkg::GAIN_W-1:0] gainAppliedB   // Code on channel B
);
	import dgs_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisation
	logic [PIN_COUNT-1:0] pinSync;       // Synchronised pins
	logic                 sclkPrev_reg;  // Previous sclk level
	logic                 csPrev_reg;    // Previous chip select level

	dgs_pin_sync u_sync (
		.mclk     (mclk),
		.resetn   (resetn),
		.pinIn    ({sdiPin, chipSelectN, sclkPin}),
		.pinReset (3'h2),
		.pinSync  (pinSync)
	);

	wire sclkS    = pinSync[0];              // Synced clock
	wire csS      = pinSync[1];              // Synced select, low active
	wire sdiS     = pinSync[2];              // Synced data
	wire csActive = !csS;                    // Selected
	wire sclkRise = sclkS && !sclkPrev_reg && csActive;
	wire sclkFall = !sclkS && sclkPrev_reg && csActive;
	wire csFall   = !csS && csPrev_reg;      // Frame start
	wire csRise   = csS && !csPrev_reg;      // Frame end

	// Edge history
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_reg <= 1'b0;
			csPrev_reg   <= 1'b1;
		end else begin
			sclkPrev_reg <= sclkS;
			csPrev_reg   <= csS;
		end
	end

	////////////////////////////////////////////////////////////////
	// Frame shift and count
	logic [FRAME_BITS-1:0] rxShift_reg;  // Received bits
	logic [CNT_W-1:0]      bitCount_reg; // Rising edges seen
	logic                  readFlag_reg; // Flag of current frame
	logic [BYTE_BITS-1:0]  txShift_reg;  // Outgoing read data

	wire [FRAME_BITS-1:0] rxNext   = {rxShift_reg[FRAME_BITS-2:0], sdiS};
	wire                  byteDone = sclkRise && (bitCount_reg == CNT_BYTE - 5'h01);
	wire [ADDR_W-1:0]     rdAddr   = rxNext[ADDR_MSB-BYTE_BITS:ADDR_LSB-BYTE_BITS];
	wire                  rdFlag   = rxNext[RW_POS-BYTE_BITS];
	wire [CNT_W-1:0]      countNext = (bitCount_reg == CNT_MAX) ? CNT_MAX
	                                  : bitCount_reg + 5'h01;

	// Counts rising edges; restarts each frame
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rxShift_reg  <= 16'h0000;
			bitCount_reg <= 5'h00;
			readFlag_reg <= 1'b0;
		end else if (csFall) begin
			bitCount_reg <= 5'h00;
			readFlag_reg <= 1'b0;
		end else if (sclkRise) begin
			rxShift_reg  <= rxNext;
			bitCount_reg <= countNext;
			if (byteDone) begin
				readFlag_reg <= rdFlag;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register bank
	logic [BYTE_BITS-1:0] gainA_reg; // gain_code_channel_a
	logic [BYTE_BITS-1:0] gainB_reg; // gain_code_channel_b
	logic [BYTE_BITS-1:0] ctrl_reg;  // channel_apply_control

	wire [ADDR_W-1:0]    wrAddr   = rxShift_reg[ADDR_MSB:ADDR_LSB];
	wire [BYTE_BITS-1:0] wrData   = rxShift_reg[BYTE_BITS-1:0];
	wire                 fullFrame = (bitCount_reg == CNT_FRAME);
	wire                 commitWr = csRise && fullFrame && !rxShift_reg[RW_POS];
	wire                 wrGainA  = commitWr && (wrAddr == ADDR_GAIN_A);
	wire                 wrGainB  = commitWr && (wrAddr == ADDR_GAIN_B);
	wire                 wrCtrl   = commitWr && (wrAddr == ADDR_CTRL);

	// Writes only at frame end; reads and short frames leave all alone
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gainA_reg <= GAIN_RESET;
			gainB_reg <= GAIN_RESET;
			ctrl_reg  <= CTRL_RESET;
		end else begin
			if (wrGainA) begin
				gainA_reg <= wrData & GAIN_MASK;
			end
			if (wrGainB) begin
				gainB_reg <= wrData & GAIN_MASK;
			end
			if (wrCtrl) begin
				ctrl_reg  <= wrData & CTRL_MASK;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	wire [BYTE_BITS-1:0] rdData =
		(rdAddr == ADDR_GAIN_A) ? gainA_reg :
		(rdAddr == ADDR_GAIN_B) ? gainB_reg :
		(rdAddr == ADDR_CTRL)   ? ctrl_reg  : 8'h00;

	////////////////////////////////////////////////////////////////
	// Serial output
	wire txWindow = (bitCount_reg >= CNT_BYTE) && (bitCount_reg < CNT_FRAME);

	// Load after first byte, shift on falling edges in the data byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			txShift_reg <= 8'h00;
			sdoOut      <= 1'b0;
			sdoOe       <= 1'b0;
		end else if (!csActive) begin
			sdoOe       <= 1'b0;
			sdoOut      <= 1'b0;
		end else if (byteDone) begin
			txShift_reg <= rdData;
		end else if (sclkFall && txWindow && readFlag_reg) begin
			sdoOut      <= txShift_reg[BYTE_BITS-1];
			sdoOe       <= 1'b1;
			txShift_reg <= {txShift_reg[BYTE_BITS-2:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////
	// Gain routing
	wire [GAIN_W-1:0] codeA = (gainA_reg[GAIN_W-1:0] > GAIN_CODE_MAX)
	                          ? GAIN_CODE_MAX : gainA_reg[GAIN_W-1:0];
	wire [GAIN_W-1:0] codeB = (gainB_reg[GAIN_W-1:0] > GAIN_CODE_MAX)
	                          ? GAIN_CODE_MAX : gainB_reg[GAIN_W-1:0];
	wire              linkOn = ctrl_reg[CTRL_LINK];
	wire              applyA = ctrl_reg[CTRL_APPLY_A];
	wire              applyB = ctrl_reg[CTRL_APPLY_B];
	wire [GAIN_W-1:0] srcB   = linkOn ? codeA : codeB;

	// Applied gains follow their source while the apply bit is set
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gainAppliedA <= GAIN_CODE_MAX;
			gainAppliedB <= GAIN_CODE_MAX;
		end else begin
			if (applyA) begin
				gainAppliedA <= codeA;
			end
			if (applyB) begin
				gainAppliedB <= srcB;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Assertions
	property p_code_legal;
		@(posedge mclk) disable iff (!resetn)
		(gainAppliedA <= GAIN_CODE_MAX) && (gainAppliedB <= GAIN_CODE_MAX)
		&& !gainA_reg[7] && !gainB_reg[7];
	endproperty
	a_code_legal: assert property (p_code_legal)
		else $error("applied gain code out of range");

	property p_link_b;
		@(posedge mclk) disable iff (!resetn)
		(linkOn && applyB) |=> (gainAppliedB == $past(codeA));
	endproperty
	a_link_b: assert property (p_link_b)
		else $error("linked channel B does not follow register 3");

	property p_split_b;
		@(posedge mclk) disable iff (!resetn)
		(!linkOn && applyB) |=> (gainAppliedB == $past(codeB));
	endproperty
	a_split_b: assert property (p_split_b)
		else $error("channel B does not follow register 4");

	property p_hold_a;
		@(posedge mclk) disable iff (!resetn)
		!applyA |=> $stable(gainAppliedA);
	endproperty
	a_hold_a: assert property (p_hold_a)
		else $error("channel A changed while apply clear");

	property p_apply_a;
		@(posedge mclk) disable iff (!resetn)
		applyA |=> (gainAppliedA == $past(codeA));
	endproperty
	a_apply_a: assert property (p_apply_a)
		else $error("channel A did not take register 3");

	property p_hold_b;
		@(posedge mclk) disable iff (!resetn)
		!applyB |=> $stable(gainAppliedB);
	endproperty
	a_hold_b: assert property (p_hold_b)
		else $error("channel B changed while apply clear");

	property p_commit_only;
		@(posedge mclk) disable iff (!resetn)
		!commitWr |=> ($stable(gainA_reg) && $stable(gainB_reg) && $stable(ctrl_reg));
	endproperty
	a_commit_only: assert property (p_commit_only)
		else $error("register changed outside a write commit");

	property p_read_no_write;
		@(posedge mclk) disable iff (!resetn)
		(csRise && rxShift_reg[RW_POS])
		|=> ($stable(gainA_reg) && $stable(gainB_reg) && $stable(ctrl_reg));
	endproperty
	a_read_no_write: assert property (p_read_no_write)
		else $error("read frame altered a register");

	property p_short_frame;
		@(posedge mclk) disable iff (!resetn)
		(csRise && (bitCount_reg != CNT_FRAME))
		|=> ($stable(gainA_reg) && $stable(gainB_reg) && $stable(ctrl_reg));
	endproperty
	a_short_frame: assert property (p_short_frame)
		else $error("short frame wrote a register");

	property p_oe_selected;
		@(posedge mclk) disable iff (!resetn)
		!csActive |=> !sdoOe;
	endproperty
	a_oe_selected: assert property (p_oe_selected)
		else $error("data out driven while not selected");

	property p_oe_read_only;
		@(posedge mclk) disable iff (!resetn)
		$rose(sdoOe) |-> (readFlag_reg && $past(txWindow));
	endproperty
	a_oe_read_only: assert property (p_oe_read_only)
		else $error("data out driven outside read data byte");

	property p_commit_full;
		@(posedge mclk) disable iff (!resetn)
		commitWr |-> (bitCount_reg == CNT_FRAME);
	endproperty
	a_commit_full: assert property (p_commit_full)
		else $error("commit without sixteen clocks");

	// Each qualified rising edge below saturation advances the count by exactly one
	property p_count_step;
		@(posedge mclk) disable iff (!resetn)
		(sclkRise && !csFall && (bitCount_reg != CNT_MAX))
		|=> (bitCount_reg == $past(bitCount_reg) + 5'h01);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("edge count did not advance by one");

	// A new selection starts the count from zero
	property p_count_clear;
		@(posedge mclk) disable iff (!resetn)
		csFall |=> (bitCount_reg == 5'h00);
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("edge count not cleared at frame start");

	// Main scenarios
	c_write_gain: cover property (@(posedge mclk) disable iff (!resetn) wrGainA);
	c_write_ctrl: cover property (@(posedge mclk) disable iff (!resetn) wrCtrl);
	c_read_out:   cover property (@(posedge mclk) disable iff (!resetn) $rose(sdoOe));
	c_short:      cover property (@(posedge mclk) disable iff (!resetn)
		csRise && (bitCount_reg < CNT_FRAME));
	c_linked:     cover property (@(posedge mclk) disable iff (!resetn) linkOn && applyB);

endmodule // dgs_gain_regs

`default_nettype wire

// ---- verif/dgs_spi_master.sv ----
// Serial controller model that sends one frame per call to the gain bank.
// Assumes mclk paces it and the device samples the pins through synchronisers.
`timescale 1ns/1ps
`default_nettype none

module dgs_spi_master (
	input  wire logic mclk,        // Core clock, used for pacing only
	input  wire logic sdoLine,     // Resolved serial out wire
	output var  logic sclkPin,     // Serial clock, idle low
	output var  logic chipSelectN, // Chip select, low active
	output var  logic sdiPin       // Serial data to the device
);
	localparam int HALF = 6; // mclk cycles per serial clock high level; each low level lasts one more

	////////////////////////////////////////////////////////////////////////////////
	// Idle levels; the clock stands still outside frames
	initial begin
		sclkPin = 1'b0;
		chipSelectN = 1'b1;
		sdiPin = 1'b0;
	end

	// One frame of nEdges clocks, MSB first; read data shifted in on rises 9..nEdges, last eight kept
	task automatic xfer(input logic [15:0] word, input int nEdges, output logic [7:0] rdData);
		int i;
		rdData = 8'h00;
		@(posedge mclk) chipSelectN <= 1'b0;
		for (i = 0; i < nEdges; i++) begin
			@(posedge mclk) sdiPin <= (i < 16) ? word[15-i] : 1'b0;
			repeat (HALF) @(posedge mclk);
			sclkPin <= 1'b1;
			if (i >= 8) rdData = {rdData[6:0], sdoLine};
			repeat (HALF) @(posedge mclk);
			sclkPin <= 1'b0;
		end
		repeat (HALF) @(posedge mclk);
		chipSelectN <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
endmodule // dgs_spi_master

`default_nettype wire

// ---- verif/dual_gain_spi_registers_tb.sv ----
// Self-checking bench for the serial gain register bank.
// Assumes the controller model drives the pins and the sdo wire pulls low.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module dual_gain_spi_registers_tb;
	import dgs_pkg::*;

	logic              mclk;         // Core clock
	logic              resetn;       // Async reset, low active
	logic              sclkPin;      // Serial clock
	logic              chipSelectN;  // Chip select
	logic              sdiPin;       // Serial data in
	logic              sdoOut;       // Serial out level
	logic              sdoOe;        // Serial out enable
	logic [GAIN_W-1:0] gainAppliedA; // Channel A code
	logic [GAIN_W-1:0] gainAppliedB; // Channel B code
	wire  logic        sdoLine;      // Resolved wire
	logic [7:0]        rdVal;        // Scratch read data
	int                n_errors = 0; // Mismatches
	int                n_tests  = 0; // Comparisons

	// Current output: bias resistor pulls the wire low when off
	assign sdoLine = sdoOe & sdoOut;

	////////////////////////////////////////////////////////////////////////////////
	dgs_gain_regs dgs_gain_regs_i (.mclk(mclk), .resetn(resetn), .sclkPin(sclkPin),
		.chipSelectN(chipSelectN), .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe(sdoOe),
		.gainAppliedA(gainAppliedA), .gainAppliedB(gainAppliedB));
	dgs_spi_master dgs_spi_master_i (.mclk(mclk), .sdoLine(sdoLine), .sclkPin(sclkPin),
		.chipSelectN(chipSelectN), .sdiPin(sdiPin));

	////////////////////////////////////////////////////////////////////////////////
	// Write frame, unused bits sent as zero
	task automatic wr(input logic [3:0] addr, input logic [7:0] data);
		logic [7:0] dummy;
		dgs_spi_master_i.xfer({1'b0, 3'h0, addr, data}, 16, dummy);
		repeat (4) @(posedge mclk);
	endtask

	// Read frame with junk in the data field
	task automatic rd(input logic [3:0] addr, input logic [7:0] expData);
		logic [7:0] got;
		dgs_spi_master_i.xfer({1'b1, 3'h0, addr, 8'hA5}, 16, got);
		`CHK(got, expData)
		`CHK(sdoOe, 1'b0)
	endtask

	// Applied codes on both channels
	task automatic gains(input logic [6:0] expA, input logic [6:0] expB);
		`CHK(gainAppliedA, expA)
		`CHK(gainAppliedB, expB)
	endtask

	// Counts, verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 250 MHz
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		conclude();
	end

	// Test sequence
	initial begin
		resetn = 1'b0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(4'h3, 8'h50);
		rd(4'h4, 8'h50);
		rd(4'h5, 8'h03);
		gains(7'h50, 7'h50);
		wr(4'h3, 8'h28);
		gains(7'h28, 7'h50);
		wr(4'h4, 8'h0A);
		gains(7'h28, 7'h0A);
		rd(4'h3, 8'h28);
		wr(4'h3, 8'hFF);
		rd(4'h3, 8'h7F);
		gains(7'h50, 7'h0A);
		wr(4'h3, 8'h20);
		wr(4'h5, 8'hFF);
		rd(4'h5, 8'h07);
		gains(7'h20, 7'h20);
		wr(4'h5, 8'h00);
		wr(4'h3, 8'h10);
		wr(4'h4, 8'h30);
		gains(7'h20, 7'h20);
		wr(4'h5, 8'h01);
		gains(7'h20, 7'h30);
		wr(4'h5, 8'h03);
		gains(7'h10, 7'h30);
		rd(4'h3, 8'h10);
		dgs_spi_master_i.xfer({1'b0, 3'h0, 4'h3, 8'h44}, 15, rdVal);
		rd(4'h3, 8'h10);
		dgs_spi_master_i.xfer({1'b0, 3'h0, 4'h3, 8'h44}, 17, rdVal);
		rd(4'h3, 8'h10);
		gains(7'h10, 7'h30);
		rd(4'h2, 8'h00);
		conclude();
	end
endmodule // dual_gain_spi_registers_tb

`undef CHK
`default_nettype wire
